// ==== event_latch.sv ====
/*
  One status register group: condition, rising-edge event latch, enable and summary.
  Assumes condition inputs synchronous to clk; read_clear clears latched events.
*/
`timescale 1ns/1ps
`include "status_defs.svh"
module event_latch #(
  parameter int W = 16
) (
  input wire logic clk,
  input wire logic rst,
  input wire logic clk_en,
  input wire logic sync_clear,
  input wire logic [W-1:0] cond,
  input wire logic [W-1:0] valid_bits,
  input wire logic enable_we,
  input wire logic [W-1:0] enable_wdata,
  input wire logic read_clear,
  input wire logic event_clear,
  output logic [W-1:0] event_q,
  output logic [W-1:0] enable_q,
  output logic summary
);
  logic [W-1:0] cond_q;
  logic [W-1:0] cond_d;
  logic [W-1:0] event_d;
  logic [W-1:0] enable_d;
  logic [W-1:0] rise;

  ////////////////////////////////////////////////////////////////////////////
  // Next state
  always_comb begin
    rise = cond & ~cond_q & valid_bits;
    cond_d = cond & valid_bits;
    event_d = event_q;
    enable_d = enable_q;
    if (read_clear || event_clear) begin
      event_d = '0;
    end
    event_d = event_d | rise;
    if (enable_we) begin
      enable_d = enable_wdata & valid_bits;
    end
    if (sync_clear) begin
      cond_d = '0;
      event_d = '0;
      enable_d = '0;
    end
  end

  always_ff @(posedge clk or posedge rst) begin
    if (rst) begin
      cond_q <= '0;
      event_q <= '0;
      enable_q <= '0;
    end else if (clk_en) begin
      cond_q <= cond_d;
      event_q <= event_d;
      enable_q <= enable_d;
    end
  end

  assign summary = |(event_q & enable_q);
endmodule : event_latch

// ==== instrument_status_reporting.sv ====
/*
  Status reporting core: standard event flags and mask, status summary byte, service
  request, serial and parallel poll, operation and questionable status with channel groups.
  Assumes command decoding outside issues one-cycle strobes synchronous to clk; the error
  queue and output queue report their state as levels; manual mode arrives from a pin.
*/
`timescale 1ns/1ps
`include "status_defs.svh"
// Functional notes
// RL1 - Masked rising event flag sets summary bit
// RL2 - Operation complete after pending commands finish
// RL3 - Query error on unrequested read or overrun
// RL4 - Device error for codes -300..-399, positive
// RL5 - Execution error for valid unexecutable command
// RL6 - Command error on syntax fault
// RL7 - User request on switch to manual
// RL8 - Power-on flag set; bit 1 unused
// RL9 - Operation status has condition and event views
// RL10 - Operation bits 1-3 show channel calibration
// RL11 - Questionable bits 3, 8, 9 summaries
// RL12 - Per-channel sub-registers; query uses selected channel
// RL13 - Service request only from bits 2,3,4,5,7
// RL14 - Only device asserts service request
// RL15 - Serial poll returns the status byte
// RL16 - Parallel poll: mask, OR, invert, drive line
// RL17 - Controller configures poll line and sense first
// RL18 - Controller sets both masks to same value
// RL19 - Controller may set all mask bits
// RL20 - Event reads clear; other reads do not
// RL21 - Masked rising status bit requests service
// RL22 - Status bit 6 shows active service request
// RL23 - Summary bit is combinational OR of masked flags
// RL24 - Synchronous power-on clear then power flag
module instrument_status_reporting (
  input wire logic clk,
  input wire logic rst,
  input wire logic clk_en,
  input wire logic power_on_clear,
  input wire status_pkg::read_sel_t rd_sel,
  input wire logic rd_stb,
  input wire status_pkg::write_sel_t wr_sel,
  input wire logic wr_stb,
  input wire status_pkg::word16_t wr_data,
  output status_pkg::word16_t rd_data,
  output logic rd_valid,
  input wire logic [1:0] channel_sel,
  input wire logic opc_received,
  input wire logic commands_idle,
  input wire logic output_read_empty,
  input wire logic command_while_pending,
  input wire logic error_logged,
  input wire logic signed [15:0] error_code,
  input wire logic error_queue_nonempty,
  input wire logic message_available,
  input wire logic manual_mode_pin,
  input wire logic [2:0] cal_busy,
  input wire logic [2:0] power_fault,
  input wire logic [2:0] cal_fault,
  input wire logic selftest_fail,
  input wire logic serial_poll,
  output status_pkg::byte8_t serial_poll_byte,
  output logic service_request,
  output logic [7:0] poll_line_out,
  output logic [7:0] poll_line_oe_n,
  output logic individual_poll_flag
);
  import status_pkg::*;

  ////////////////////////////////////////////////////////////////////////////
  // Signals
  byte8_t standard_event_flags_q, standard_event_flags_d;
  byte8_t standard_event_mask_q, standard_event_mask_d;
  byte8_t service_request_mask_q, service_request_mask_d;
  byte8_t parallel_poll_mask_q, parallel_poll_mask_d;
  byte8_t status_summary_byte;
  byte8_t stb_prev_q, stb_prev_d;
  byte8_t flag_set;
  byte8_t spoll_q, spoll_d;
  logic [2:0] pp_line_q, pp_line_d;
  logic pp_sense_q, pp_sense_d;
  logic pp_cfg_q, pp_cfg_d;
  logic srq_q, srq_d;
  logic opc_wait_q, opc_wait_d;
  logic pwr_pend_q, pwr_pend_d;
  logic manual_meta_q, manual_sync_q, manual_prev_q;
  word16_t rd_data_q, rd_data_d;
  logic rd_valid_q, rd_valid_d;
  logic event_summary_bit;
  logic master_summary_bit;
  logic oper_summary, ques_summary;
  word16_t oper_cond, oper_event, oper_enable;
  word16_t ques_cond, ques_event, ques_enable;
  logic read_flags, clear_all;
  logic [`CH_COUNT-1:0] ch_summary;
  word16_t ch_event [`CH_COUNT];
  word16_t ch_enable [`CH_COUNT];
  word16_t ch_cond [`CH_COUNT];
  word16_t oper_valid, ques_valid, ch_valid;
  logic ppoll_bit;

  assign clear_all = wr_stb && (wr_sel == WR_CLEAR);
  assign read_flags = rd_stb && (rd_sel == RD_EVENT_FLAGS);

  ////////////////////////////////////////////////////////////////////////////
  // Manual-mode pin synchroniser
  always_ff @(posedge clk or posedge rst) begin
    if (rst) begin
      manual_meta_q <= 1'b0;
      manual_sync_q <= 1'b0;
      manual_prev_q <= 1'b0;
    end else if (clk_en) begin
      manual_meta_q <= manual_mode_pin;
      manual_sync_q <= manual_meta_q;
      manual_prev_q <= manual_sync_q;
    end
  end

  ////////////////////////////////////////////////////////////////////////////
  // Channel sub-registers and summary groups
  always_comb begin
    oper_valid = `WORD_ZERO;
    oper_valid[`OPER_CAL_A] = 1'b1; // RL10
    oper_valid[`OPER_CAL_B] = 1'b1;
    oper_valid[`OPER_CAL_USB] = 1'b1;
    ques_valid = `WORD_ZERO;
    ques_valid[`QUES_POWER] = 1'b1; // RL11
    ques_valid[`QUES_CAL] = 1'b1;
    ques_valid[`QUES_SELFTEST] = 1'b1;
    ch_valid = ques_valid;
    ch_valid[`QUES_SELFTEST] = 1'b0;
  end

  genvar gi;
  generate
    for (gi = 0; gi < `CH_COUNT; gi++) begin : g_ch
      always_comb begin
        ch_cond[gi] = `WORD_ZERO;
        ch_cond[gi][`QUES_POWER] = power_fault[gi];
        ch_cond[gi][`QUES_CAL] = cal_fault[gi];
      end
      event_latch #(.W(16)) u_ch (
        .clk(clk),
        .rst(rst),
        .clk_en(clk_en),
        .sync_clear(power_on_clear),
        .cond(ch_cond[gi]),
        .valid_bits(ch_valid),
        .enable_we(wr_stb && (wr_sel == WR_CH_ENABLE) && (channel_sel == gi)),
        .enable_wdata(wr_data),
        .read_clear(rd_stb && (rd_sel == RD_CH_EVENT) && (channel_sel == gi)),
        .event_clear(clear_all),
        .event_q(ch_event[gi]),
        .enable_q(ch_enable[gi]),
        .summary(ch_summary[gi])
      );
    end
  endgenerate

  always_comb begin
    oper_cond = `WORD_ZERO;
    oper_cond[`OPER_CAL_A] = cal_busy[0]; // RL10
    oper_cond[`OPER_CAL_B] = cal_busy[1];
    oper_cond[`OPER_CAL_USB] = cal_busy[2];
    ques_cond = `WORD_ZERO;
    ques_cond[`QUES_POWER] = |power_fault; // RL12
    ques_cond[`QUES_CAL] = |cal_fault; // RL12
    ques_cond[`QUES_SELFTEST] = selftest_fail; // RL11
  end

  event_latch #(.W(16)) u_oper (
    .clk(clk),
    .rst(rst),
    .clk_en(clk_en),
    .sync_clear(power_on_clear),
    .cond(oper_cond),
    .valid_bits(oper_valid),
    .enable_we(wr_stb && (wr_sel == WR_OPER_ENABLE)),
    .enable_wdata(wr_data),
    .read_clear(rd_stb && (rd_sel == RD_OPER_EVENT)), // RL20
    .event_clear(clear_all),
    .event_q(oper_event),
    .enable_q(oper_enable),
    .summary(oper_summary)
  );

  event_latch #(.W(16)) u_ques (
    .clk(clk),
    .rst(rst),
    .clk_en(clk_en),
    .sync_clear(power_on_clear),
    .cond(ques_cond),
    .valid_bits(ques_valid),
    .enable_we(wr_stb && (wr_sel == WR_QUES_ENABLE)),
    .enable_wdata(wr_data),
    .read_clear(rd_stb && (rd_sel == RD_QUES_EVENT)), // RL20
    .event_clear(clear_all),
    .event_q(ques_event),
    .enable_q(ques_enable),
    .summary(ques_summary)
  );

  ////////////////////////////////////////////////////////////////////////////
  // Standard event flags and status byte
  always_comb begin
    flag_set = `BYTE_ZERO;
    flag_set[`EVF_OPC] = opc_wait_q && commands_idle; // RL2
    flag_set[`EVF_QUERY] = output_read_empty || command_while_pending; // RL3
    flag_set[`EVF_DEVICE] = error_logged && ((error_code <= -16'sd300 && error_code >= -16'sd399)
                            || error_code > 16'sd0); // RL4
    flag_set[`EVF_EXEC] = error_logged && error_code <= -16'sd200
                          && error_code > -16'sd300; // RL5
    flag_set[`EVF_COMMAND] = error_logged && error_code <= -16'sd100
                             && error_code > -16'sd200; // RL6
    flag_set[`EVF_USER] = manual_sync_q && !manual_prev_q; // RL7
    flag_set[`EVF_POWER] = pwr_pend_q; // RL8
  end

  assign event_summary_bit = |(standard_event_flags_q & standard_event_mask_q); // RL23 RL1

  always_comb begin
    status_summary_byte = `BYTE_ZERO;
    status_summary_byte[`SSB_ERRQ] = error_queue_nonempty;
    status_summary_byte[`SSB_QUES] = ques_summary;
    status_summary_byte[`SSB_MAV] = message_available;
    status_summary_byte[`SSB_ESB] = event_summary_bit; // RL1
    status_summary_byte[`SSB_OPER] = oper_summary;
    status_summary_byte[`SSB_MSS] = master_summary_bit; // RL22
  end

  assign master_summary_bit = srq_q;

  always_comb begin
    standard_event_flags_d = standard_event_flags_q;
    standard_event_mask_d = standard_event_mask_q;
    service_request_mask_d = service_request_mask_q;
    parallel_poll_mask_d = parallel_poll_mask_q;
    pp_line_d = pp_line_q;
    pp_sense_d = pp_sense_q;
    pp_cfg_d = pp_cfg_q;
    opc_wait_d = opc_wait_q;
    pwr_pend_d = 1'b0;
    stb_prev_d = status_summary_byte;
    srq_d = srq_q;
    spoll_d = spoll_q;
    if (opc_received) begin
      opc_wait_d = 1'b1;
    end else if (flag_set[`EVF_OPC]) begin
      opc_wait_d = 1'b0;
    end
    if (read_flags || clear_all) begin
      standard_event_flags_d = `BYTE_ZERO; // RL20
    end
    standard_event_flags_d = standard_event_flags_d | flag_set;
    if (wr_stb) begin
      if (wr_sel == WR_EVENT_MASK) begin
        standard_event_mask_d = wr_data[7:0];
      end else if (wr_sel == WR_SRQ_MASK) begin
        service_request_mask_d = wr_data[7:0];
      end else if (wr_sel == WR_PP_MASK) begin
        parallel_poll_mask_d = wr_data[7:0];
      end else if (wr_sel == WR_PP_CONFIG) begin
        pp_line_d = wr_data[2:0]; // RL17
        pp_sense_d = wr_data[3];
        pp_cfg_d = wr_data[4];
      end
    end
    // Service request rises on a masked 0-to-1 edge; bit 6 mask ignored
    if (|(status_summary_byte & ~stb_prev_q & service_request_mask_q & `SRQ_SOURCES)) begin
      srq_d = 1'b1; // RL21 RL13 RL14
    end else if (!(|(status_summary_byte & service_request_mask_q & `SRQ_SOURCES))) begin
      srq_d = 1'b0;
    end else if (serial_poll) begin
      srq_d = 1'b0;
    end
    if (serial_poll) begin
      spoll_d = status_summary_byte; // RL15
    end
    if (power_on_clear) begin
      standard_event_flags_d = `BYTE_ZERO; // RL24
      standard_event_mask_d = `BYTE_ZERO;
      service_request_mask_d = `BYTE_ZERO;
      parallel_poll_mask_d = `BYTE_ZERO;
      pp_cfg_d = 1'b0;
      pp_line_d = `LINE_ZERO;
      pp_sense_d = 1'b0;
      opc_wait_d = 1'b0;
      srq_d = 1'b0;
      stb_prev_d = `BYTE_ZERO;
      pwr_pend_d = 1'b1; // RL24 RL8
    end
  end

  ////////////////////////////////////////////////////////////////////////////
  // Read path
  always_comb begin
    rd_data_d = rd_data_q;
    rd_valid_d = rd_stb;
    if (rd_stb) begin
      if (rd_sel == RD_EVENT_FLAGS) begin
        rd_data_d = {8'h00, standard_event_flags_q};
      end else if (rd_sel == RD_EVENT_MASK) begin
        rd_data_d = {8'h00, standard_event_mask_q};
      end else if (rd_sel == RD_STATUS_BYTE) begin
        rd_data_d = {8'h00, status_summary_byte};
      end else if (rd_sel == RD_SRQ_MASK) begin
        rd_data_d = {8'h00, service_request_mask_q};
      end else if (rd_sel == RD_PP_MASK) begin
        rd_data_d = {8'h00, parallel_poll_mask_q};
      end else if (rd_sel == RD_OPER_COND) begin
        rd_data_d = oper_cond & oper_valid; // RL9
      end else if (rd_sel == RD_OPER_EVENT) begin
        rd_data_d = oper_event; // RL9
      end else if (rd_sel == RD_QUES_COND) begin
        rd_data_d = ques_cond;
      end else if (rd_sel == RD_QUES_EVENT) begin
        rd_data_d = ques_event;
      end else if (rd_sel == RD_CH_COND && channel_sel <= `SEL_USB) begin
        rd_data_d = ch_cond[channel_sel] & ch_valid; // RL12
      end else if (rd_sel == RD_CH_EVENT && channel_sel <= `SEL_USB) begin
        rd_data_d = ch_event[channel_sel]; // RL12
      end else if (rd_sel == RD_IND_FLAG) begin
        rd_data_d = {15'h0000, ppoll_bit};
      end else begin
        rd_data_d = `WORD_ZERO;
      end
    end
  end

  always_ff @(posedge clk or posedge rst) begin
    if (rst) begin
      standard_event_flags_q <= `BYTE_ZERO;
      standard_event_mask_q <= `BYTE_ZERO;
      service_request_mask_q <= `BYTE_ZERO;
      parallel_poll_mask_q <= `BYTE_ZERO;
      pp_line_q <= `LINE_ZERO;
      pp_sense_q <= 1'b0;
      pp_cfg_q <= 1'b0;
      opc_wait_q <= 1'b0;
      pwr_pend_q <= 1'b1;
      stb_prev_q <= `BYTE_ZERO;
      srq_q <= 1'b0;
      spoll_q <= `BYTE_ZERO;
      rd_data_q <= `WORD_ZERO;
      rd_valid_q <= 1'b0;
    end else if (clk_en) begin
      standard_event_flags_q <= standard_event_flags_d;
      standard_event_mask_q <= standard_event_mask_d;
      service_request_mask_q <= service_request_mask_d;
      parallel_poll_mask_q <= parallel_poll_mask_d;
      pp_line_q <= pp_line_d;
      pp_sense_q <= pp_sense_d;
      pp_cfg_q <= pp_cfg_d;
      opc_wait_q <= opc_wait_d;
      pwr_pend_q <= pwr_pend_d;
      stb_prev_q <= stb_prev_d;
      srq_q <= srq_d;
      spoll_q <= spoll_d;
      rd_data_q <= rd_data_d;
      rd_valid_q <= rd_valid_d;
    end
  end

  ////////////////////////////////////////////////////////////////////////////
  // Parallel poll response
  assign ppoll_bit = |(parallel_poll_mask_q & status_summary_byte); // RL16
  assign individual_poll_flag = ppoll_bit;

  generate
    for (gi = 0; gi < `POLL_LINES; gi++) begin : g_pp
      assign poll_line_out[gi] = ppoll_bit ^ pp_sense_q; // RL16
      assign poll_line_oe_n[gi] = !(pp_cfg_q && (pp_line_q == gi));
    end
  endgenerate

  assign rd_data = rd_data_q;
  assign rd_valid = rd_valid_q;
  assign serial_poll_byte = spoll_q;
  assign service_request = srq_q;
endmodule : instrument_status_reporting

// ==== poll_partner.sv ====
/*
  Bus controller model: answers a service request by a serial poll, resolves poll lines.
  Assumes released poll lines are pulled low.
*/
`timescale 1ns/1ps
module poll_partner (
  input wire logic clk,
  input wire logic rst,
  input wire logic service_request,
  input wire logic answer_en,
  input wire logic slow,
  input wire logic [7:0] poll_line_out,
  input wire logic [7:0] poll_line_oe_n,
  output logic serial_poll,
  output logic [7:0] poll_bus
);
  logic [3:0] wait_q;
  logic [3:0] wait_d;
  logic poll_d;
  always_comb begin
    poll_d = 1'b0;
    wait_d = 4'h0;
    if (answer_en && service_request && !serial_poll) begin
      wait_d = wait_q + 4'h1;
      poll_d = wait_q >= (slow ? 4'h6 : 4'h1);
    end
    if (poll_d) begin
      wait_d = 4'h0;
    end
  end
  always_ff @(posedge clk or posedge rst) begin
    if (rst) begin
      wait_q <= 4'h0;
      serial_poll <= 1'b0;
    end else begin
      wait_q <= wait_d;
      serial_poll <= poll_d;
    end
  end
  assign poll_bus = poll_line_out & ~poll_line_oe_n;
endmodule : poll_partner

// ==== status_defs.svh ====
/*
  Constants of the instrument status reporting block: bit positions, widths, reset values.
  Assumes inclusion by bare name from the package and the design modules.
*/
`ifndef STATUS_DEFS_SVH
`define STATUS_DEFS_SVH
`define EVF_OPC 0
`define EVF_QUERY 2
`define EVF_DEVICE 3
`define EVF_EXEC 4
`define EVF_COMMAND 5
`define EVF_USER 6
`define EVF_POWER 7
`define SSB_ERRQ 2
`define SSB_QUES 3
`define SSB_MAV 4
`define SSB_ESB 5
`define SSB_MSS 6
`define SSB_OPER 7
`define OPER_CAL_A 1
`define OPER_CAL_B 2
`define OPER_CAL_USB 3
`define QUES_POWER 3
`define QUES_CAL 8
`define QUES_SELFTEST 9
`define SRQ_SOURCES 8'hBC
`define BYTE_ZERO 8'h00
`define WORD_ZERO 16'h0000
`define WORD_ONES 16'hFFFF
`define CH_COUNT 3
`define SEL_ZERO 2'h0
`define SEL_USB 2'h2
`define POLL_LINES 8
`define LINE_ZERO 3'h0
`endif

// ==== status_pkg.sv ====
/*
  Types shared by the status reporting block.
  Assumes status_defs.svh on the include path.
*/
package status_pkg;
  `include "status_defs.svh"
  typedef logic [7:0] byte8_t;
  typedef logic [15:0] word16_t;
  typedef enum logic [3:0] {
    RD_NONE = 4'b0000,
    RD_EVENT_FLAGS = 4'b0001,
    RD_EVENT_MASK = 4'b0010,
    RD_STATUS_BYTE = 4'b0011,
    RD_SRQ_MASK = 4'b0100,
    RD_PP_MASK = 4'b0101,
    RD_OPER_COND = 4'b0110,
    RD_OPER_EVENT = 4'b0111,
    RD_QUES_COND = 4'b1000,
    RD_QUES_EVENT = 4'b1001,
    RD_CH_COND = 4'b1010,
    RD_CH_EVENT = 4'b1011,
    RD_IND_FLAG = 4'b1100
  } read_sel_t;
  typedef enum logic [3:0] {
    WR_NONE = 4'b0000,
    WR_EVENT_MASK = 4'b0001,
    WR_SRQ_MASK = 4'b0010,
    WR_PP_MASK = 4'b0011,
    WR_OPER_ENABLE = 4'b0100,
    WR_QUES_ENABLE = 4'b0101,
    WR_CH_ENABLE = 4'b0110,
    WR_CLEAR = 4'b0111,
    WR_PP_CONFIG = 4'b1000
  } write_sel_t;
endpackage : status_pkg

// ==== status_properties.sv ====
/*
  Port checker of the status reporting block, bound onto the top module.
  Assumes one clock domain, async active-high reset, one-cycle read strobes.
*/
`timescale 1ns/1ps
module status_properties (
  input wire logic clk,
  input wire logic rst,
  input wire logic clk_en,
  input wire logic power_on_clear,
  input wire status_pkg::read_sel_t rd_sel,
  input wire logic rd_stb,
  input wire status_pkg::word16_t rd_data,
  input wire logic rd_valid,
  input wire logic serial_poll,
  input wire status_pkg::byte8_t serial_poll_byte,
  input wire logic service_request,
  input wire logic [7:0] poll_line_oe_n,
  input wire logic individual_poll_flag
);
  import status_pkg::*;
  default clocking cb @(posedge clk); endclocking
  default disable iff (rst);
  logic take;
  assign take = rd_stb && clk_en;
  ////////////////////////////////////////////////////////////////////////////////
  read_answer_a: assert property (take |=> rd_valid)
    else $error("read gave no answer");
  read_hold_a: assert property (!take && clk_en && !power_on_clear |=>
    !rd_valid && $stable(rd_data)) else $error("read data moved without a read");
  flag_bits_a: assert property (take && rd_sel == RD_EVENT_FLAGS |=>
    rd_data[15:8] == 8'h00 && !rd_data[1]) else $error("unused flag bits set");
  oper_bits_a: assert property (take && rd_sel inside {RD_OPER_COND, RD_OPER_EVENT}
    |=> (rd_data & 16'hFFF1) == 16'h0000) else $error("unused operation bits set");
  ques_bits_a: assert property (take && rd_sel inside {RD_QUES_COND, RD_QUES_EVENT}
    |=> (rd_data & 16'hFCF7) == 16'h0000) else $error("unused questionable bits set");
  ind_read_a: assert property (take && rd_sel == RD_IND_FLAG |=>
    rd_data == {15'h0000, $past(individual_poll_flag)}) else $error("poll flag read wrong");
  one_line_a: assert property ($onehot0(~poll_line_oe_n))
    else $error("more than one poll line driven");
  poll_byte_a: assert property (serial_poll && clk_en |=>
    serial_poll_byte[6] == $past(service_request) && serial_poll_byte[1:0] == 2'h0)
    else $error("serial poll byte wrong");
  power_clear_a: assert property (power_on_clear && clk_en |=>
    !service_request && &poll_line_oe_n) else $error("power clear left state");
  srq_rise_c: cover property ($rose(service_request));
  srq_poll_c: cover property (serial_poll && service_request);
  line_drive_c: cover property (!(&poll_line_oe_n));
endmodule : status_properties

bind instrument_status_reporting status_properties u_props (.clk(clk), .rst(rst),
  .clk_en(clk_en), .power_on_clear(power_on_clear), .rd_sel(rd_sel), .rd_stb(rd_stb),
  .rd_data(rd_data), .rd_valid(rd_valid), .serial_poll(serial_poll),
  .serial_poll_byte(serial_poll_byte), .service_request(service_request),
  .poll_line_oe_n(poll_line_oe_n), .individual_poll_flag(individual_poll_flag));

// ==== tb.sv ====
/*
  Self-checking bench of the status reporting block with a bus controller model.
  Assumes the design, package, checker and partner compiled before it.
*/
`timescale 1ns/1ps
module tb;
  import status_pkg::*;
  logic clk = 1'b0, rst = 1'b1, rd_stb = 1'b0, wr_stb = 1'b0, power_on_clear = 1'b0;
  logic opc_received = 1'b0, commands_idle = 1'b1, output_read_empty = 1'b0;
  logic command_while_pending = 1'b0, error_logged = 1'b0, selftest_fail = 1'b0;
  logic error_queue_nonempty = 1'b0, message_available = 1'b0, manual_mode_pin = 1'b0;
  logic answer_en = 1'b0, slow = 1'b0, clk_en = 1'b1;
  logic [1:0] channel_sel = 2'h0;
  logic [2:0] cal_busy = 3'h0, power_fault = 3'h0, cal_fault = 3'h0;
  logic signed [15:0] error_code = 16'h0000;
  read_sel_t rd_sel = RD_NONE;
  write_sel_t wr_sel = WR_NONE;
  word16_t wr_data = 16'h0000, rd_data;
  byte8_t serial_poll_byte, m;
  logic rd_valid, serial_poll, service_request, individual_poll_flag;
  logic [7:0] poll_line_out, poll_line_oe_n, poll_bus;
  int num_errors = 0, checked = 0, seed = 32'hCE424C40, c, n;
  int corner[7] = '{-100, -199, -200, -299, -300, -399, 7};
  instrument_status_reporting uut (.clk(clk), .rst(rst), .clk_en(clk_en),
    .power_on_clear(power_on_clear), .rd_sel(rd_sel), .rd_stb(rd_stb), .wr_sel(wr_sel),
    .wr_stb(wr_stb), .wr_data(wr_data), .rd_data(rd_data), .rd_valid(rd_valid),
    .channel_sel(channel_sel), .opc_received(opc_received), .commands_idle(commands_idle),
    .output_read_empty(output_read_empty), .command_while_pending(command_while_pending),
    .error_logged(error_logged), .error_code(error_code),
    .error_queue_nonempty(error_queue_nonempty), .message_available(message_available),
    .manual_mode_pin(manual_mode_pin), .cal_busy(cal_busy), .power_fault(power_fault),
    .cal_fault(cal_fault), .selftest_fail(selftest_fail), .serial_poll(serial_poll),
    .serial_poll_byte(serial_poll_byte), .service_request(service_request),
    .poll_line_out(poll_line_out), .poll_line_oe_n(poll_line_oe_n),
    .individual_poll_flag(individual_poll_flag));
  poll_partner ctl (.clk(clk), .rst(rst), .service_request(service_request),
    .answer_en(answer_en), .slow(slow), .poll_line_out(poll_line_out),
    .poll_line_oe_n(poll_line_oe_n), .serial_poll(serial_poll), .poll_bus(poll_bus));
  ////////////////////////////////////////////////////////////////////////////////
  function automatic byte8_t flag_for(input int code);
    if (code > 0 || (code <= -300 && code >= -399)) return 8'h08;
    if (code <= -200) return 8'h10;
    if (code <= -100) return 8'h20;
    return 8'h00;
  endfunction : flag_for
  task automatic chk(input word16_t got, input word16_t exp, input string what);
    checked++;
    if (got !== exp) begin
      num_errors++;
      $display("CHECK FAILED %0t %s got %h expected %h", $time, what, got, exp);
    end
  endtask : chk
  task automatic rd(input read_sel_t s, input word16_t exp, input string what);
    @(posedge clk);
    rd_sel <= s;
    rd_stb <= 1'b1;
    @(posedge clk);
    rd_stb <= 1'b0;
    #1;
    chk({15'h0000, rd_valid}, 16'h0001, "read answer");
    chk(rd_data, exp, what);
    @(posedge clk);
  endtask : rd
  task automatic wr(input write_sel_t s, input word16_t d);
    @(posedge clk);
    wr_sel <= s;
    wr_data <= d;
    wr_stb <= 1'b1;
    @(posedge clk);
    wr_stb <= 1'b0;
  endtask : wr
  task automatic err(input int code);
    @(posedge clk);
    error_code <= code[15:0];
    error_logged <= 1'b1;
    @(posedge clk);
    error_logged <= 1'b0;
  endtask : err
  task automatic test_done;
    $display("checked %0d num_errors %0d", checked, num_errors);
    if (num_errors == 0 && checked > 0) begin
      $display("TEST PASSED");
    end else begin
      $display("TEST FAILED");
    end
    $finish;
  endtask : test_done
  ////////////////////////////////////////////////////////////////////////////////
  initial begin
    forever #12.5 clk = ~clk;
  end
  initial begin
    repeat (5000) @(posedge clk);
    num_errors++;
    test_done;
  end
  initial begin
    repeat (6) @(posedge clk);
    rst <= 1'b0;
    rd(RD_EVENT_FLAGS, 16'h0080, "power flag");
    rd(RD_EVENT_FLAGS, 16'h0000, "flags after read");
    for (int i = 0; i < 15; i++) begin
      c = (i < 7) ? corner[i] : -100 - int'($unsigned($random(seed)) % 300);
      err(c);
      rd(RD_EVENT_FLAGS, {8'h00, flag_for(c)}, "error flag");
    end
    @(posedge clk);
    output_read_empty <= 1'b1;
    @(posedge clk);
    output_read_empty <= 1'b0;
    command_while_pending <= 1'b1;
    @(posedge clk);
    command_while_pending <= 1'b0;
    rd(RD_EVENT_FLAGS, 16'h0004, "query error");
    @(posedge clk);
    commands_idle <= 1'b0;
    opc_received <= 1'b1;
    @(posedge clk);
    opc_received <= 1'b0;
    rd(RD_EVENT_FLAGS, 16'h0000, "early completion");
    commands_idle <= 1'b1;
    repeat (2) @(posedge clk);
    rd(RD_EVENT_FLAGS, 16'h0001, "completion");
    manual_mode_pin <= 1'b1;
    repeat (5) @(posedge clk);
    rd(RD_EVENT_FLAGS, 16'h0040, "user request");
    m = 8'($random(seed));
    cal_busy <= m[2:0];
    rd(RD_OPER_COND, {12'h000, m[2:0], 1'b0}, "oper cond");
    rd(RD_OPER_EVENT, {12'h000, m[2:0], 1'b0}, "oper event");
    rd(RD_OPER_EVENT, 16'h0000, "oper event cleared");
    channel_sel <= 2'h1;
    power_fault <= 3'b010;
    cal_fault <= 3'b100;
    selftest_fail <= 1'b1;
    rd(RD_QUES_COND, 16'h0308, "ques cond");
    rd(RD_CH_COND, 16'h0008, "channel B");
    channel_sel <= 2'h2;
    rd(RD_CH_COND, 16'h0100, "channel USB");
    wr(WR_EVENT_MASK, {8'h00, m});
    rd(RD_EVENT_MASK, {8'h00, m}, "mask");
    rd(RD_EVENT_MASK, {8'h00, m}, "mask kept");
    wr(WR_EVENT_MASK, 16'h00FF);
    wr(WR_SRQ_MASK, 16'h0040);
    error_queue_nonempty <= 1'b1;
    message_available <= 1'b1;
    err(-150);
    repeat (3) @(posedge clk);
    rd(RD_STATUS_BYTE, 16'h0034, "status byte");
    #1;
    chk({15'h0000, service_request}, 16'h0000, "bit 6 mask");
    rd(RD_EVENT_FLAGS, 16'h0020, "flags");
    error_queue_nonempty <= 1'b0;
    message_available <= 1'b0;
    wr(WR_SRQ_MASK, 16'h00FF);
    wr(WR_PP_MASK, 16'h00FF);
    wr(WR_PP_CONFIG, 16'h0013);
    err(-150);
    repeat (3) @(posedge clk);
    #1;
    chk({15'h0000, service_request}, 16'h0001, "request");
    chk({8'h00, poll_bus}, 16'h0008, "poll line");
    chk({8'h00, poll_line_oe_n}, 16'h00F7, "poll enable");
    chk({15'h0000, individual_poll_flag}, 16'h0001, "poll flag pin");
    rd(RD_STATUS_BYTE, 16'h0060, "status summary");
    rd(RD_IND_FLAG, 16'h0001, "poll flag");
    wr(WR_PP_CONFIG, 16'h001B);
    #1;
    chk({8'h00, poll_line_out & ~poll_line_oe_n}, 16'h0000, "inverted line");
    rd(RD_EVENT_FLAGS, 16'h0020, "flags");
    repeat (3) @(posedge clk);
    rd(RD_STATUS_BYTE, 16'h0000, "summary cleared");
    answer_en <= 1'b1;
    slow <= 1'b1;
    #1;
    chk({15'h0000, service_request}, 16'h0000, "request dropped");
    err(-250);
    n = 0;
    while (serial_poll !== 1'b1 && n < 30) begin
      @(posedge clk);
      #1;
      n++;
    end
    @(posedge clk);
    #1;
    chk({8'h00, serial_poll_byte}, 16'h0060, "serial poll");
    repeat (3) @(posedge clk);
    answer_en <= 1'b0;
    #1;
    chk({15'h0000, service_request}, 16'h0000, "request served");
    @(posedge clk);
    power_on_clear <= 1'b1;
    @(posedge clk);
    power_on_clear <= 1'b0;
    rd(RD_EVENT_FLAGS, 16'h0080, "power flag again");
    rd(RD_SRQ_MASK, 16'h0000, "mask cleared");
    clk_en <= 1'b0;
    err(-150);
    clk_en <= 1'b1;
    rd(RD_EVENT_FLAGS, 16'h0000, "frozen");
    test_done;
  end
endmodule : tb
